// ===== hdl/mirq_pkg.sv
// Operation
// [RL1] Mode bits 14:13 pick waveform sample source
// [RL2] Mode bit 15 accumulates positive power only
// [RL3] Each event sets its status flag
// [RL4] Enabled set flag pulls request line low
// [RL5] Host reads status first when serviced
// [RL6] Bit 0: active energy MSB rises
// [RL7] Bit 1: line voltage sag seen
// [RL8] Bit 2: half line cycle accumulation done
// [RL9] Bit 3: new waveform sample written
// [RL10] Bit 4 follows zero crossing output
// [RL11] Bit 5: temperature result ready
// [RL12] Bit 6 set after reset, never requests
// [RL13] Bit 7: active energy accumulator overflow
// [RL14] Bits 8, 9: voltage, current peak exceeded
// [RL15] Apparent energy half full and overflow flags
// [RL16] Zero crossing timeout flag
// [RL17] Power sign change flags, both directions
// [RL18] Clear-on-read status; request released afterwards
package mirq_pkg;
  localparam int ADDR_W = 6;
  localparam int REG_W = 16;
  localparam int SAMPLE_W = 24;
  localparam logic [5:0] ADDR_MODE = 6'h09;
  localparam logic [5:0] ADDR_IRQ_EN = 6'h0A;
  localparam logic [5:0] ADDR_IRQ_FLAGS = 6'h0B;
  localparam logic [5:0] ADDR_IRQ_CLR_RD = 6'h0C;
  localparam logic [15:0] MODE_RESET = 16'h000C;
  localparam logic [15:0] IRQ_EN_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_RESET = 16'h0000;
  localparam logic [15:0] FLAGS_IMPL = 16'h7FFF;
  localparam int MODE_SWRST_BIT = 6;
  localparam int MODE_SRC_LO = 13;
  localparam int MODE_POS_BIT = 15;
  localparam int F_AE_HALF = 0;
  localparam int F_SAG = 1;
  localparam int F_CYC_DONE = 2;
  localparam int F_NEW_SAMPLE = 3;
  localparam int F_ZX = 4;
  localparam int F_TEMP = 5;
  localparam int F_RESET = 6;
  localparam int F_AE_OVF = 7;
  localparam int F_V_PEAK = 8;
  localparam int F_I_PEAK = 9;
  localparam int F_VA_HALF = 10;
  localparam int F_VA_OVF = 11;
  localparam int F_ZX_TO = 12;
  localparam int F_POS = 13;
  localparam int F_NEG = 14;
  typedef enum logic [1:0] {
    MIRQ_SRC_POWER = 2'h0,
    MIRQ_SRC_RSVD = 2'h1,
    MIRQ_SRC_CH1 = 2'h2,
    MIRQ_SRC_CH2 = 2'h3
  } mirq_src_t;
endpackage

// ===== hdl/mirq_cfg_if.sv
`timescale 1ns/1ns
interface mirq_cfg_if;
  logic [1:0] src_sel;
  logic pos_only;
  logic wave_new;
  modport ctrl (output src_sel, output pos_only, input wave_new);
  modport wave (input src_sel, input pos_only, output wave_new);
endinterface

// ===== hdl/mirq_wave.sv
`timescale 1ns/1ns
module mirq_wave #(
  parameter int SAMPLE_W = mirq_pkg::SAMPLE_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Mode fields in, sample event out
  mirq_cfg_if.wave cfg,
  // Sample sources
  input wire logic sample_strobe,
  input wire logic [SAMPLE_W-1:0] power_lowpass_output,
  input wire logic [SAMPLE_W-1:0] ch1_sample,
  input wire logic [SAMPLE_W-1:0] ch2_sample,
  input wire logic power_negative,
  // Results
  output logic [SAMPLE_W-1:0] wave_q,
  output logic accum_enable
);
  logic [SAMPLE_W-1:0] pick;
  logic take;
  logic new_q;

  // Reserved source code leaves the waveform register untouched
  assign take = sample_strobe && (cfg.src_sel != mirq_pkg::MIRQ_SRC_RSVD);
  assign pick = (cfg.src_sel == mirq_pkg::MIRQ_SRC_CH1) ? ch1_sample :
                (cfg.src_sel == mirq_pkg::MIRQ_SRC_CH2) ? ch2_sample :
                power_lowpass_output; // RL1
  assign accum_enable = !(cfg.pos_only && power_negative); // RL2
  assign cfg.wave_new = new_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wave_q <= '0;
      new_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (take)
        wave_q <= pick; // RL1
      new_q <= take;
    end
  end

  neg_blocked_a: assert property (@(posedge mclk) disable iff (!rst_n)
    cfg.pos_only && power_negative |-> !accum_enable) // RL2
    else $error("negative power accumulated in positive-only mode");
endmodule

// ===== hdl/mirq_top.sv
`timescale 1ns/1ns
module mirq_top #(
  parameter int SAMPLE_W = mirq_pkg::SAMPLE_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [mirq_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [mirq_pkg::REG_W-1:0] reg_wdata,
  output logic [mirq_pkg::REG_W-1:0] reg_rdata,
  // Metering events; energy MSB, zero crossing and power sign inputs are levels, the rest one-cycle pulses
  input wire logic active_energy_msb,
  input wire logic sag_detect,
  input wire logic line_cycle_done,
  input wire logic zero_cross_state,
  input wire logic temp_ready,
  input wire logic active_energy_overflow,
  input wire logic voltage_peak_flag,
  input wire logic current_peak_flag,
  input wire logic apparent_energy_msb,
  input wire logic apparent_energy_overflow,
  input wire logic zero_cross_timeout,
  input wire logic power_negative,
  // Waveform sample sources
  input wire logic sample_strobe,
  input wire logic [SAMPLE_W-1:0] power_lowpass_output,
  input wire logic [SAMPLE_W-1:0] ch1_sample,
  input wire logic [SAMPLE_W-1:0] ch2_sample,
  // Datapath controls
  output logic [SAMPLE_W-1:0] wave_data,
  output logic accum_enable,
  output logic [1:0] sample_source_select,
  output logic positive_only_accumulate,
  // Open-drain request line
  output logic irq_n_level,
  output logic irq_n_oe
);
  logic [15:0] mode_q;
  logic [15:0] en_q;
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic [15:0] events;
  logic [15:0] clr_mask;
  logic [15:0] rd_mux;
  logic ae_msb_q;
  logic va_msb_q;
  logic neg_q;
  logic rst_pend_q;
  logic wr_mode;
  logic wr_en;
  logic rd_clr;
  logic swrst;
  logic irq_active;
  mirq_cfg_if cfg ();

  assign wr_mode = reg_wr && (reg_addr == mirq_pkg::ADDR_MODE);
  assign wr_en = reg_wr && (reg_addr == mirq_pkg::ADDR_IRQ_EN);
  assign rd_clr = reg_rd && (reg_addr == mirq_pkg::ADDR_IRQ_CLR_RD);
  assign swrst = wr_mode && reg_wdata[mirq_pkg::MODE_SWRST_BIT];

  assign sample_source_select = mode_q[mirq_pkg::MODE_SRC_LO +: 2]; // RL1
  assign positive_only_accumulate = mode_q[mirq_pkg::MODE_POS_BIT]; // RL2
  assign cfg.src_sel = sample_source_select;
  assign cfg.pos_only = positive_only_accumulate;

  // Event map into status bits
  assign events[mirq_pkg::F_AE_HALF] = active_energy_msb && !ae_msb_q; // RL6
  assign events[mirq_pkg::F_SAG] = sag_detect; // RL7
  assign events[mirq_pkg::F_CYC_DONE] = line_cycle_done; // RL8
  assign events[mirq_pkg::F_NEW_SAMPLE] = cfg.wave_new; // RL9
  assign events[mirq_pkg::F_ZX] = 1'b0;
  assign events[mirq_pkg::F_TEMP] = temp_ready; // RL11
  assign events[mirq_pkg::F_RESET] = rst_pend_q; // RL12
  assign events[mirq_pkg::F_AE_OVF] = active_energy_overflow; // RL13
  assign events[mirq_pkg::F_V_PEAK] = voltage_peak_flag; // RL14
  assign events[mirq_pkg::F_I_PEAK] = current_peak_flag; // RL14
  assign events[mirq_pkg::F_VA_HALF] = apparent_energy_msb && !va_msb_q; // RL15
  assign events[mirq_pkg::F_VA_OVF] = apparent_energy_overflow; // RL15
  assign events[mirq_pkg::F_ZX_TO] = zero_cross_timeout; // RL16
  assign events[mirq_pkg::F_POS] = neg_q && !power_negative; // RL17
  assign events[mirq_pkg::F_NEG] = !neg_q && power_negative; // RL17
  assign events[15] = 1'b0;

  // Set wins over clear-on-read; bit 4 is a live copy of zero crossing
  assign clr_mask = rd_clr ? 16'hFFFF : 16'h0000; // RL18
  always_comb
  begin
    flags_d = ((flags_q & ~clr_mask) | events) & mirq_pkg::FLAGS_IMPL; // RL3
    flags_d[mirq_pkg::F_ZX] = zero_cross_state; // RL10
  end

  assign rd_mux = (reg_addr == mirq_pkg::ADDR_MODE) ? mode_q :
                  (reg_addr == mirq_pkg::ADDR_IRQ_EN) ? en_q :
                  (reg_addr == mirq_pkg::ADDR_IRQ_FLAGS) ? flags_q :
                  (reg_addr == mirq_pkg::ADDR_IRQ_CLR_RD) ? flags_q :
                  16'h0000;

  // Reset flag can never raise a request
  assign irq_active = |(flags_q & en_q &
                        ~(16'h0001 << mirq_pkg::F_RESET)); // RL4 RL12
  assign irq_n_level = 1'b0;
  assign irq_n_oe = irq_active; // RL4 RL18

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_q <= mirq_pkg::MODE_RESET;
      en_q <= mirq_pkg::IRQ_EN_RESET;
      flags_q <= mirq_pkg::FLAGS_RESET;
      reg_rdata <= 16'h0000;
      ae_msb_q <= 1'b0;
      va_msb_q <= 1'b0;
      neg_q <= 1'b0;
      rst_pend_q <= 1'b1;
    end
    else if (clk_en)
    begin
      ae_msb_q <= active_energy_msb;
      va_msb_q <= apparent_energy_msb;
      neg_q <= power_negative;
      if (reg_rd)
        reg_rdata <= rd_mux; // RL18
      if (swrst)
      begin
        mode_q <= mirq_pkg::MODE_RESET;
        en_q <= mirq_pkg::IRQ_EN_RESET;
        flags_q <= mirq_pkg::FLAGS_RESET;
        rst_pend_q <= 1'b1; // RL12
      end
      else
      begin
        if (wr_mode)
          mode_q <= reg_wdata;
        if (wr_en)
          en_q <= reg_wdata;
        flags_q <= flags_d;
        rst_pend_q <= 1'b0;
      end
    end
  end

  mirq_wave #(
    .SAMPLE_W(SAMPLE_W)
  ) u_wave (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .cfg(cfg),
    .sample_strobe(sample_strobe),
    .power_lowpass_output(power_lowpass_output),
    .ch1_sample(ch1_sample),
    .ch2_sample(ch2_sample),
    .power_negative(power_negative),
    .wave_q(wave_data),
    .accum_enable(accum_enable)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence rd_clear_s;
    clk_en && rd_clr && !swrst && (events == 16'h0000);
  endsequence
  sequence sw_reset_s;
    clk_en && swrst;
  endsequence
  sequence run_on_s;
    clk_en && !swrst;
  endsequence

  sag_sets_a: assert property (clk_en && sag_detect && !swrst // RL7
    |=> flags_q[mirq_pkg::F_SAG])
    else $error("sag event did not set its flag");
  half_full_a: assert property (clk_en && active_energy_msb // RL6
    && !ae_msb_q && !swrst |=> flags_q[mirq_pkg::F_AE_HALF])
    else $error("active energy half full flag missing");
  irq_drive_a: assert property (run_on_s ##0 (sag_detect // RL4
    && en_q[mirq_pkg::F_SAG] && !wr_en) |=> irq_n_oe)
    else $error("enabled flag did not pull the request line");
  reset_quiet_a: assert property (en_q[mirq_pkg::F_RESET] // RL12
    && ((flags_q & en_q) == (16'h0001 << mirq_pkg::F_RESET)) |-> !irq_n_oe)
    else $error("reset flag raised a request");
  zx_follow_a: assert property (run_on_s |=> flags_q[mirq_pkg::F_ZX] // RL10
    == $past(zero_cross_state))
    else $error("zero crossing bit does not follow input");
  clear_read_a: assert property (rd_clear_s |=> // RL18
    reg_rdata == $past(flags_q)
    && (flags_q & ~(16'h0001 << mirq_pkg::F_ZX)) == 16'h0000)
    else $error("clear-on-read failed");
  swap_pos_a: assert property (clk_en && neg_q && !power_negative // RL17
    && !swrst |=> flags_q[mirq_pkg::F_POS])
    else $error("power turned positive not flagged");
  swap_neg_a: assert property (clk_en && !neg_q && power_negative // RL17
    && !swrst |=> flags_q[mirq_pkg::F_NEG])
    else $error("power turned negative not flagged");
  mode_src_a: assert property (run_on_s ##0 wr_mode |=> // RL1
    sample_source_select == $past(reg_wdata[mirq_pkg::MODE_SRC_LO +: 2]))
    else $error("sample source field not written");
  mode_pos_a: assert property (run_on_s ##0 wr_mode |=> // RL2
    positive_only_accumulate == $past(reg_wdata[mirq_pkg::MODE_POS_BIT]))
    else $error("positive-only field not written");
  set_wins_a: assert property (clk_en && rd_clr && !swrst // RL11 RL3
    && temp_ready |=> flags_q[mirq_pkg::F_TEMP])
    else $error("event lost during clear-on-read");
  irq_release_a: assert property (rd_clear_s ##0 (!wr_en // RL18
    && !zero_cross_state) |=> !irq_n_oe)
    else $error("request line held after clearing read");
  sw_restore_a: assert property (sw_reset_s |=> // RL12
    mode_q == mirq_pkg::MODE_RESET && en_q == mirq_pkg::IRQ_EN_RESET
    && flags_q == mirq_pkg::FLAGS_RESET)
    else $error("software reset did not restore registers");
  sw_flag_a: assert property (sw_reset_s ##1 run_on_s |=> // RL12
    flags_q[mirq_pkg::F_RESET])
    else $error("reset flag missing after software reset");
  rsvd_hold_a: assert property (clk_en && sample_strobe // RL1
    && sample_source_select == mirq_pkg::MIRQ_SRC_RSVD
    |=> $stable(wave_data))
    else $error("reserved source code loaded the waveform register");
  cyc_done_a: assert property (run_on_s ##0 line_cycle_done |=> // RL8
    flags_q[mirq_pkg::F_CYC_DONE])
    else $error("line cycle end not flagged");
  wave_flag_a: assert property (run_on_s ##0 (sample_strobe // RL9
    && sample_source_select != mirq_pkg::MIRQ_SRC_RSVD) ##1 run_on_s
    |=> flags_q[mirq_pkg::F_NEW_SAMPLE])
    else $error("new waveform sample not flagged");
endmodule

// ===== test/mirq_host.sv
`timescale 1ns/1ns
module mirq_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [mirq_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [mirq_pkg::REG_W-1:0] reg_wdata,
  input wire logic [mirq_pkg::REG_W-1:0] reg_rdata
);
  initial
  begin
    reg_addr = 6'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One strobe cycle; address and data are scrambled once released
  task automatic access(input logic w, input logic [5:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    @(negedge mclk);
    q = reg_rdata;
  endtask
  // Status is read before the clearing read
  task automatic service(output logic [15:0] st, output logic [15:0] cl);
    access(1'b0, mirq_pkg::ADDR_IRQ_FLAGS, 16'h0000, st);
    access(1'b0, mirq_pkg::ADDR_IRQ_CLR_RD, 16'h0000, cl);
  endtask
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [12:0] drv = 13'h0000;
  logic [71:0] smp = 72'h0;
  logic [5:0] addr;
  logic wr, rd, aen, pos, ion, ioe;
  logic [15:0] wd, rdt, q, q2, mf, men, x;
  logic [23:0] wav, ew;
  logic [1:0] sel, msrc;
  int errors = 0;
  int total_checks = 0;
  int seed = 32'h8A26E022;
  int pm [8] = '{1, 2, 5, 7, 8, 9, 11, 12};
  always #20 mclk = ~mclk;
  mirq_host mirq_host_inst (.mclk(mclk), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdt));
  // Clock enable drops once to check that state freezes
  mirq_top mirq_top_inst (.mclk(mclk), .rst_n(rst_n), .clk_en(ce),
    .reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wd),
    .reg_rdata(rdt), .active_energy_msb(drv[8]), .sag_detect(drv[0]),
    .line_cycle_done(drv[1]), .zero_cross_state(drv[12]),
    .temp_ready(drv[2]), .active_energy_overflow(drv[3]),
    .voltage_peak_flag(drv[4]), .current_peak_flag(drv[5]),
    .apparent_energy_msb(drv[9]), .apparent_energy_overflow(drv[6]),
    .zero_cross_timeout(drv[7]), .power_negative(drv[10]),
    .sample_strobe(drv[11]), .power_lowpass_output(smp[23:0]),
    .ch1_sample(smp[47:24]), .ch2_sample(smp[71:48]), .wave_data(wav),
    .accum_enable(aen), .sample_source_select(sel),
    .positive_only_accumulate(pos), .irq_n_level(ion), .irq_n_oe(ioe));
  task automatic chk(input logic [23:0] s, input logic [23:0] e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    mirq_host_inst.access(1'b1, a, d, q);
  endtask
  task automatic rd_reg(input logic [5:0] a);
    mirq_host_inst.access(1'b0, a, 16'h0000, q);
  endtask
  // Sparse random events; model tracks edges of the level inputs
  task automatic burst(input int n);
    logic [15:0] r;
    logic [15:0] e;
    for (int i = 0; i < n; i++)
    begin
      @(negedge mclk);
      r = 16'($random(seed) & $random(seed));
      e = 16'h0000;
      for (int j = 0; j < 8; j++)
        e[pm[j]] = r[j];
      e[0] = r[8] & !drv[8];
      e[10] = r[9] & !drv[9];
      e[13] = drv[10] & !r[10];
      e[14] = !drv[10] & r[10];
      e[3] = r[11] & (msrc != 2'h1);
      mf = mf | e;
      drv = r[12:0];
    end
    @(negedge mclk);
    drv[7:0] = 8'h00;
    drv[11] = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  task automatic verify;
    x = mf | {11'h000, drv[12], 4'h0};
    chk(ioe, |(x & men & 16'hFFBF));
    chk(ion, 1'b0);
    mirq_host_inst.service(q, q2);
    chk(q, x);
    chk(q2, x);
    mf = 16'h0000;
    x = {11'h000, drv[12], 4'h0};
    chk(ioe, |(x & men));
    rd_reg(mirq_pkg::ADDR_IRQ_FLAGS);
    chk(q, x);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Tests need under 1500 cycles; 5000 cycles is ample
  initial
  begin
    #200000;
    errors++;
    conclude;
  end
  initial
  begin
    mf = 16'h0040;
    men = 16'h0000;
    msrc = 2'h0;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    rd_reg(mirq_pkg::ADDR_MODE);
    chk(q, 16'h000C);
    rd_reg(6'h3F);
    chk(q, 16'h0000);
    $display("reset values done");
    for (int k = 0; k < 6; k++)
    begin
      men = 16'($random(seed)) & 16'h7FFF;
      wr_reg(mirq_pkg::ADDR_IRQ_EN, men);
      rd_reg(mirq_pkg::ADDR_IRQ_EN);
      chk(q, men);
      burst(20);
      wr_reg(mirq_pkg::ADDR_IRQ_FLAGS, 16'hFFFF);
      wr_reg(mirq_pkg::ADDR_IRQ_CLR_RD, 16'hFFFF);
      verify;
    end
    $display("event flags done");
    ew = 24'h000000;
    for (int c = 0; c < 4; c++)
    begin
      msrc = c[1:0];
      smp = 72'({$random(seed), $random(seed), $random(seed)});
      wr_reg(mirq_pkg::ADDR_MODE, {c[0], c[1:0], 13'h000C});
      rd_reg(mirq_pkg::ADDR_MODE);
      chk(q, {c[0], c[1:0], 13'h000C});
      chk({pos, sel}, {c[0], c[1:0]});
      drv[11] = 1'b1;
      @(negedge mclk);
      drv[11] = 1'b0;
      mf[3] = mf[3] | (c != 1);
      if (c != 1)
        ew = smp[24*(c == 0 ? 0 : c - 1) +: 24];
      repeat (2) @(negedge mclk);
      chk(wav, ew);
      for (int p = 0; p < 2; p++)
      begin
        @(negedge mclk);
        mf[drv[10] ? 13 : 14] = 1'b1;
        drv[10] = !drv[10];
        #1 chk(aen, !(c[0] & drv[10]));
      end
      repeat (2) @(negedge mclk);
      verify;
    end
    $display("mode fields done");
    mf[13] = mf[13] | drv[10];
    drv = 13'h0000;
    repeat (2) @(negedge mclk);
    wr_reg(mirq_pkg::ADDR_MODE, 16'h004C);
    mf = 16'h0040;
    men = 16'h0000;
    msrc = 2'h0;
    rd_reg(mirq_pkg::ADDR_MODE);
    chk(q, 16'h000C);
    men = 16'h0040;
    wr_reg(mirq_pkg::ADDR_IRQ_EN, men);
    verify;
    $display("software reset done");
    ce = 1'b0;
    drv[0] = 1'b1;
    @(negedge mclk);
    ce = 1'b1;
    drv[0] = 1'b0;
    rd_reg(mirq_pkg::ADDR_IRQ_FLAGS);
    chk(q, 16'h0000);
    fork
      rd_reg(mirq_pkg::ADDR_IRQ_CLR_RD);
      begin
        @(negedge mclk);
        drv[2] = 1'b1;
        @(negedge mclk);
        drv[2] = 1'b0;
      end
    join
    mf = 16'h0020;
    verify;
    $display("freeze and set-wins done");
    conclude;
  end
endmodule
